/* edge_sync.sv */
// two flip-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module edge_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clock_en,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clock) begin
    // reset to the pin's idle level, else a false edge follows reset
    if (srst) begin
      meta <= IDLE_LEVEL;
      sync <= IDLE_LEVEL;
      prev <= IDLE_LEVEL;
    end else if (clock_en) begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule : edge_sync

/* gain_host.sv */
// host model that shifts gain words into the loader
`timescale 1ns/1ps
module gain_host (
  input  wire logic clock,
  output logic      shift_clock,
  output logic      serial_data,
  output logic      latch_strobe
);
  initial begin
    shift_clock  = 1'b0;
    serial_data  = 1'b0;
    latch_strobe = 1'b1;
  end
  // ==========================================================
  // pin timing, 320 ns shift clock
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  // msb first, clock idles low outside frames
  task automatic shift_bits(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = bits[i];
      tick(4);
      shift_clock = 1'b1;
      tick(4);
      shift_clock = 1'b0;
    end
    serial_data = ~serial_data; // line inverted after the last bit, no stale level
  endtask : shift_bits
  // strobe low around all edges, rise well after the last
  task automatic frame(input logic [15:0] bits, input int n);
    latch_strobe = 1'b0;
    tick(4);
    shift_bits(bits, n);
    tick(4);
    latch_strobe = 1'b1;
    tick(4);
  endtask : frame
endmodule : gain_host

/* gain_loader_pkg.sv */
// package of constants for the serial gain word loader
package gain_loader_pkg;
  // ==========================================================
  // word layout
  localparam int WORD_BITS = 8;
  localparam int RANGE_BIT = 7;
  localparam int CODE_BITS = 7;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  // ==========================================================
  // gain model factors, micro units
  localparam int VERNIER_UNITS = 55744;
  localparam int BOOST_UNITS   = 7079458;
endpackage : gain_loader_pkg

/* serial_gain_word_loader.sv */
// serial gain word loader: shift, latch and gain outputs
`timescale 1ns/1ps
// Functional notes
// RQ1 - eight bit word, bits accepted only while latch strobe is low
// RQ2 - each shift clock rising edge shifts the data level in
// RQ3 - strobe rising edge copies shift register into active gain register
// RQ4 - top bit chooses high range when one, low range when zero
// RQ5 - lower seven bits are unsigned vernier code, 0 to 127
// RQ6 - vernier code zero disables the transconductance stage
// RQ7 - power on reset loads low range, code zero
// RQ8 - power enable low leaves the gain register untouched
// RQ9 - gain equals code times 0.055744, times 7.079458 in high range
// RQ10 - host shifts msb first, raises strobe after eighth edge
// RQ11 - extra edges keep only the last eight bits
module serial_gain_word_loader
  import gain_loader_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 clock_en,
  input  wire logic                 shift_clock,
  input  wire logic                 serial_data,
  input  wire logic                 latch_strobe,
  input  wire logic                 power_enable,
  output logic [WORD_BITS-1:0]      gain_word,
  output logic                      high_gain_range,
  output logic [CODE_BITS-1:0]      vernier_code,
  output logic                      gm_stage_on,
  output logic                      amp_active,
  output logic                      load_done
);
  // ==========================================================
  // pin synchronisers
  logic sclk_level;
  logic sclk_rise;
  logic strobe_level;
  logic strobe_rise;
  logic data_meta;
  logic data_sync;
  logic pwr_meta;
  logic pwr_sync;

  edge_sync #(
    .IDLE_LEVEL (1'b0)
  ) u_sclk (
    .clock    (clock),
    .srst     (srst),
    .clock_en (clock_en),
    .pin      (shift_clock),
    .level    (sclk_level),
    .rise     (sclk_rise),
    .fall     ()
  );

  // strobe idles high between frames
  edge_sync #(
    .IDLE_LEVEL (1'b1)
  ) u_strobe (
    .clock    (clock),
    .srst     (srst),
    .clock_en (clock_en),
    .pin      (latch_strobe),
    .level    (strobe_level),
    .rise     (strobe_rise),
    .fall     ()
  );

  // data delayed like the clock so it matches the detected edge
  always_ff @(posedge clock) begin
    if (srst) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
      pwr_meta  <= 1'b0;
      pwr_sync  <= 1'b0;
    end else if (clock_en) begin
      data_meta <= serial_data;
      data_sync <= data_meta;
      pwr_meta  <= power_enable;
      pwr_sync  <= pwr_meta;
    end
  end

  // ==========================================================
  // shift register and active gain register
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] next_shift_reg;
  logic [WORD_BITS-1:0] next_gain_word;
  logic                 next_amp_active;
  logic                 next_load_done;

  always_comb begin
    next_shift_reg  = shift_reg;
    next_gain_word  = gain_word;
    next_load_done  = 1'b0;
    next_amp_active = pwr_sync;
    // older bits fall off the top, so only the last eight stay
    if (sclk_rise && !strobe_level) begin // [RQ1] [RQ2] [RQ11]
      next_shift_reg = {shift_reg[WORD_BITS-2:0], data_sync}; // [RQ10]
    end
    // power enable is not looked at here, so power-down keeps the word
    if (strobe_rise) begin // [RQ3] [RQ8]
      next_gain_word = shift_reg;
      next_load_done = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      shift_reg  <= GAIN_RESET;
      gain_word  <= GAIN_RESET; // [RQ7]
      load_done  <= 1'b0;
      amp_active <= 1'b0;
    end else if (clock_en) begin
      shift_reg  <= next_shift_reg;
      gain_word  <= next_gain_word;
      load_done  <= next_load_done;
      amp_active <= next_amp_active;
    end
  end

  // ==========================================================
  // decoded gain fields, registered for clean outputs
  logic next_high;
  logic next_gm_on;

  always_comb begin
    next_high  = next_gain_word[RANGE_BIT]; // [RQ4]
    next_gm_on = (next_gain_word[CODE_BITS-1:0] != 7'h00); // [RQ5] [RQ6]
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      high_gain_range <= 1'b0;
      vernier_code    <= 7'h00;
      gm_stage_on     <= 1'b0;
    end else if (clock_en) begin
      high_gain_range <= next_high;
      vernier_code    <= next_gain_word[CODE_BITS-1:0]; // [RQ5] [RQ9]
      gm_stage_on     <= next_gm_on;
    end
  end

  // ==========================================================
  // edge count per frame, feeds the long frame cover only
  logic [3:0] edge_count;
  logic [3:0] next_edge_count;

  always_comb begin
    next_edge_count = edge_count;
    if (strobe_rise) begin
      next_edge_count = 4'h0;
    end else if (sclk_rise && !strobe_level && (edge_count != 4'hf)) begin
      // saturate so a very long frame never wraps to a small count
      next_edge_count = edge_count + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      edge_count <= 4'h0;
    end else if (clock_en) begin
      edge_count <= next_edge_count;
    end
  end

  // ==========================================================
  // checks
  // assertions watch the synchronised pins, the same view the logic has

  a_latch_copies: assert property (@(posedge clock) disable iff (srst) // [RQ3]
    clock_en && strobe_rise |=> gain_word == $past(shift_reg) && load_done)
    else $error("gain word not loaded on strobe rise");
  a_hold_no_strobe: assert property (@(posedge clock) disable iff (srst) // [RQ8]
    clock_en && !strobe_rise |=> $stable(gain_word))
    else $error("gain word changed without strobe");
  a_shift_blocked: assert property (@(posedge clock) disable iff (srst) // [RQ1]
    clock_en && strobe_level |=> $stable(shift_reg))
    else $error("shift while strobe high");
  a_shift_in: assert property (@(posedge clock) disable iff (srst) // [RQ2]
    clock_en && sclk_rise && !strobe_level |=>
      shift_reg == {$past(shift_reg[6:0]), $past(data_sync)})
    else $error("shift register did not take data");
  a_range_bit: assert property (@(posedge clock) disable iff (srst) // [RQ4]
    clock_en |=> high_gain_range == gain_word[RANGE_BIT])
    else $error("range output mismatch");
  a_code_field: assert property (@(posedge clock) disable iff (srst) // [RQ5]
    clock_en |=> vernier_code == gain_word[6:0])
    else $error("vernier code mismatch");
  a_gm_off_zero: assert property (@(posedge clock) disable iff (srst) // [RQ6]
    vernier_code == 7'h00 |-> !gm_stage_on)
    else $error("gm stage on at code zero");
  a_reset_value: assert property (@(posedge clock) // [RQ7]
    srst |=> gain_word == GAIN_RESET && !high_gain_range && !gm_stage_on)
    else $error("reset value wrong");
  a_power_keep: assert property (@(posedge clock) disable iff (srst) // [RQ8]
    clock_en && $fell(pwr_sync) && !strobe_rise |=> $stable(gain_word))
    else $error("power down disturbed gain");
  a_freeze_hold: assert property (@(posedge clock) disable iff (srst) // [RQ3]
    !clock_en |=> $stable(gain_word) && $stable(shift_reg) && $stable(load_done))
    else $error("state moved while clock enable low");
  a_done_pulse: assert property (@(posedge clock) disable iff (srst) // [RQ3]
    clock_en && load_done |=> !load_done)
    else $error("load done longer than one cycle");
  a_gm_on_code: assert property (@(posedge clock) disable iff (srst) // [RQ6]
    vernier_code != 7'h00 |-> gm_stage_on)
    else $error("gm stage off at nonzero code");
  a_amp_follow: assert property (@(posedge clock) disable iff (srst) // [RQ8]
    clock_en |=> amp_active == $past(pwr_sync))
    else $error("amp active does not follow power enable");

  // ==========================================================
  // covers

  c_load: cover property (@(posedge clock) disable iff (srst) load_done);
  c_high: cover property (@(posedge clock) disable iff (srst) load_done && high_gain_range);
  c_zero: cover property (@(posedge clock) disable iff (srst)
    load_done && !gm_stage_on);
  c_long_frame: cover property (@(posedge clock) disable iff (srst) // [RQ11]
    strobe_rise && edge_count > 4'h8);
  c_load_powered_down: cover property (@(posedge clock) disable iff (srst) // [RQ8]
    load_done && !amp_active);
endmodule : serial_gain_word_loader

/* serial_gain_word_loader_tb.sv */
// self-checking bench for the serial gain word loader
`timescale 1ns/1ps
module serial_gain_word_loader_tb;
  import gain_loader_pkg::*;
  logic                 clock, srst, power_enable, clock_en;
  logic                 shift_clock, serial_data, latch_strobe;
  logic [WORD_BITS-1:0] gain_word, sreg, exp;
  logic [CODE_BITS-1:0] vernier_code;
  logic                 high_gain_range, gm_stage_on, amp_active, load_done;
  logic [7:0]           q[$];
  logic [31:0]          rnd;
  int                   fail_count, check_count, seed;
  gain_host host (.clock(clock), .shift_clock(shift_clock), .serial_data(serial_data),
    .latch_strobe(latch_strobe));
  serial_gain_word_loader dut (
    .clock           (clock),
    .srst            (srst),
    .clock_en        (clock_en),
    .shift_clock     (shift_clock),
    .serial_data     (serial_data),
    .latch_strobe    (latch_strobe),
    .power_enable    (power_enable),
    .gain_word       (gain_word),
    .high_gain_range (high_gain_range),
    .vernier_code    (vernier_code),
    .gm_stage_on     (gm_stage_on),
    .amp_active      (amp_active),
    .load_done       (load_done)
  );
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // linear gain in micro volts per volt, boost applied in the high range
  function automatic logic [31:0] gain_micro(input logic [7:0] w);
    longint g;
    g = longint'(w[6:0]) * VERNIER_UNITS;
    if (w[RANGE_BIT]) g = g * BOOST_UNITS / 1000000;
    return 32'(g);
  endfunction : gain_micro
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // model shift register keeps the last eight bits
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) sreg = {sreg[6:0], bits[i]};
    q.push_back(sreg);
    host.frame(bits, n);
    for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge clock);
    if (q.size() != 0) begin
      fail_count++;
      test_done();
    end
  endtask : send
  // ==========================================================
  // monitor: negedge sees settled registered outputs
  always @(negedge clock) begin
    if (load_done === 1'b1) begin
      if (q.size() == 0) check("load_done", 16'h1, 16'h0);
      else begin
        exp = q.pop_front();
        check("gain_word", gain_word, exp);
        check("high_gain_range", high_gain_range, exp[RANGE_BIT]);
        check("vernier_code", vernier_code, exp[6:0]);
        check("gm_stage_on", gm_stage_on, exp[6:0] != 7'h00);
        check("gain_micro", gain_micro({high_gain_range, vernier_code}), gain_micro(exp));
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    power_enable = 1'b1;
    clock_en = 1'b1;
    sreg = 8'h00;
    seed = 32'h0d6c;
    repeat (12) @(posedge clock);
    #2 srst = 1'b0;
    host.tick(6);
    check("gain_word", gain_word, GAIN_RESET);
    check("amp_active", amp_active, 1'b1);
    send(16'h00ad, 8);
    send(16'h0080, 8);
    send(16'h007f, 8);
    send(16'h0000, 8);
    for (int k = 0; k < 6; k++) begin
      rnd = $random(seed);
      send({8'h00, rnd[7:0]}, 8);
    end
    send(16'h03c5, 10);
    host.shift_bits(16'h005a, 8); // strobe high, edges ignored
    send(16'h0000, 0);
    power_enable = 1'b0;
    host.tick(6);
    check("amp_active", amp_active, 1'b0);
    check("gain_word", gain_word, sreg);
    send(16'h00e3, 8); // loading not blocked while powered down
    power_enable = 1'b1;
    host.tick(6);
    check("gain_word", gain_word, sreg);
    check("amp_active", amp_active, 1'b1);
    // frozen core must miss a whole frame and keep its word
    clock_en = 1'b0;
    rnd = $random(seed);
    host.frame({8'h00, rnd[7:0]}, 8);
    clock_en = 1'b1;
    host.tick(3);
    check("gain_word", gain_word, sreg);
    srst = 1'b1;
    host.tick(3);
    srst = 1'b0;
    host.tick(6);
    check("gain_word", gain_word, GAIN_RESET);
    send(16'h0031, 8);
    test_done();
  end
endmodule : serial_gain_word_loader_tb
